// ### rtl/ida_alu.v
// Data-path unit for subtract-with-borrow, bit test and exclusive OR
`timescale 1ns/1ns
`default_nettype none
`include "ida_defs.vh"

module ida_alu (
	// Operation select and operands
	input  wire [1:0]          op,
	input  wire [`IDA_DW-1:0]  a,
	input  wire [`IDA_DW-1:0]  b,
	input  wire                carry_in,
	// Results
	output reg  [`IDA_DW-1:0]  result,
	output reg                 write_en,
	output reg                 carry_out,
	output reg                 zero_out
);

	// Nine-bit difference keeps the borrow as its top bit
	wire [`IDA_DW:0] diff = {1'b0, a} - {1'b0, b} - {{`IDA_DW{1'b0}}, carry_in};
	wire [`IDA_DW-1:0] andv = a & b;
	wire [`IDA_DW-1:0] xorv = a ^ b;

	// Zero tests the stored 8 bits, so -256 also reads as zero
	always @* begin
		result    = a;
		write_en  = 1'b0;
		carry_out = carry_in;
		zero_out  = 1'b0;
		case (op)
			`IDA_ALU_SUBC: begin
				result    = diff[`IDA_DW-1:0];          // [RL1]
				write_en  = 1'b1;                       // [RL4]
				carry_out = diff[`IDA_DW];              // [RL2]
				zero_out  = (diff[`IDA_DW-1:0] == `IDA_ZERO8); // [RL3]
			end
			`IDA_ALU_TEST: begin
				result    = a;                          // [RL5]
				write_en  = 1'b0;                       // [RL5]
				carry_out = ^andv;                      // [RL6]
				zero_out  = (andv == `IDA_ZERO8);       // [RL5]
			end
			`IDA_ALU_XOR: begin
				result    = xorv;                       // [RL8]
				write_en  = 1'b1;
				carry_out = 1'b0;                       // [RL9]
				zero_out  = (xorv == `IDA_ZERO8);       // [RL8]
			end
			default: begin
				result    = a;
				write_en  = 1'b0;
				carry_out = carry_in;
				zero_out  = 1'b0;
			end
		endcase
	end

endmodule // ida_alu
`default_nettype wire

// ### rtl/ida_decoder.v
// Instruction decoder with flag state, program counter and operation execution
`timescale 1ns/1ns
`default_nettype none
`include "ida_defs.vh"

module ida_decoder (
	// Clock and reset
	input  wire                 sys_clk,
	input  wire                 rst_n,
	// Instruction from program memory
	input  wire [`IDA_IW-1:0]   instr,
	input  wire                 instr_valid,
	// Register file read data
	input  wire [`IDA_DW-1:0]   first_register_data,
	input  wire [`IDA_DW-1:0]   second_register_data,
	// Register file indices and write port
	output wire [3:0]           first_register_operand,
	output wire [3:0]           second_register_operand,
	output reg                  reg_write,
	output reg  [3:0]           reg_write_index,
	output reg  [`IDA_DW-1:0]   reg_write_data,
	// Flags and interrupt enable
	output reg                  carry_flag,
	output reg                  zero_flag,
	output reg                  interrupt_enable,
	// Program counter
	output reg  [`IDA_AW-1:0]   program_counter,
	// Decoded class strobes
	output reg                  dec_add,
	output reg                  dec_add_with_carry_op,
	output reg                  dec_and,
	output reg                  dec_compare,
	output reg                  dec_fetch,
	output reg                  dec_input,
	output reg                  dec_call,
	output reg                  dec_jump,
	output reg                  dec_branch_taken,
	output reg                  dec_illegal,
	// Decoded operand fields
	output reg                  use_register_operand,
	output reg  [`IDA_DW-1:0]   immediate_constant,
	output reg  [`IDA_DW-1:0]   port_number,
	output reg  [`IDA_SPW-1:0]  scratch_address,
	output reg  [`IDA_AW-1:0]   branch_target
);

	// Field slices of the raw word
	wire [4:0] op5 = instr[`IDA_OP5_HI:`IDA_OP5_LO];
	wire [5:0] op6 = instr[`IDA_OP5_HI:`IDA_OP6_LO];
	wire       sel = instr[`IDA_SEL_BIT];                             // [RL11]
	wire [1:0] cc  = instr[`IDA_COND_HI:`IDA_COND_LO];
	wire [`IDA_DW-1:0] kfield = instr[`IDA_K_HI:`IDA_K_LO];
	wire low4_zero = (instr[`IDA_LOW4_HI:0] == `IDA_ZERO4);
	wire hi2_zero  = (instr[`IDA_HI2_HI:`IDA_HI2_LO] == `IDA_ZERO2);

	assign first_register_operand  = instr[`IDA_RX_HI:`IDA_RX_LO];   // [RL10]
	assign second_register_operand = instr[`IDA_RY_HI:`IDA_RY_LO];   // [RL11]

	// Operand for two-operand forms: immediate or second register
	wire [`IDA_DW-1:0] operand_b = sel ? second_register_data : kfield; // [RL4] [RL7]

	// Condition evaluation on present flags
	reg cond_true;
	always @* begin
		case (cc)
			`IDA_CC_Z:  cond_true = zero_flag;                            // [RL17]
			`IDA_CC_NZ: cond_true = ~zero_flag;                           // [RL17]
			`IDA_CC_C:  cond_true = carry_flag;                           // [RL17]
			`IDA_CC_NC: cond_true = ~carry_flag;                          // [RL17]
			default:    cond_true = 1'b0;
		endcase
	end

	// Register-operand forms must hold zero in bits 3:0
	wire two_op_ok = ~sel | low4_zero;                                 // [RL11]

	// Opcode matches
	wire m_subc  = (op5 == `IDA_OP_SUBC)  & two_op_ok;
	wire m_test  = (op5 == `IDA_OP_TEST)  & two_op_ok;
	wire m_xor   = (op5 == `IDA_OP_XOR)   & two_op_ok;
	wire m_add   = (op5 == `IDA_OP_ADD)   & two_op_ok;                 // [RL12]
	wire m_addc  = (op5 == `IDA_OP_ADDC)  & two_op_ok;                 // [RL12]
	wire m_and   = (op5 == `IDA_OP_AND)   & two_op_ok;                 // [RL13]
	wire m_cmp   = (op5 == `IDA_OP_CMP)   & two_op_ok;                 // [RL13]
	wire m_fetch = (op5 == `IDA_OP_FETCH) & (sel ? low4_zero : hi2_zero); // [RL14]
	wire m_input = (op5 == `IDA_OP_INPUT) & two_op_ok;                 // [RL15]
	wire ucond   = (cc == `IDA_CC_Z);
	wire m_call  = ((op6 == `IDA_OP6_CALL) & ucond) | (op6 == `IDA_OP6_CALLC); // [RL16]
	wire m_jump  = ((op6 == `IDA_OP6_JUMP) & ucond) | (op6 == `IDA_OP6_JUMPC); // [RL18]
	wire m_intc  = (op6 == `IDA_OP6_INTC) &
		(instr[`IDA_IE_MID_HI:`IDA_IE_MID_LO] == `IDA_ZERO11);         // [RL19]
	wire m_cond  = (op6 == `IDA_OP6_CALLC) | (op6 == `IDA_OP6_JUMPC);

	// Words outside every known pattern raise the illegal strobe
	wire m_known = m_subc | m_test | m_xor | m_add | m_addc | m_and | m_cmp |
		m_fetch | m_input | m_call | m_jump | m_intc;

	// Data-path operation select
	reg [1:0] alu_op;
	always @* begin
		if (m_subc) begin
			alu_op = `IDA_ALU_SUBC;
		end else if (m_test) begin
			alu_op = `IDA_ALU_TEST;
		end else if (m_xor) begin
			alu_op = `IDA_ALU_XOR;
		end else begin
			alu_op = `IDA_ALU_NONE;
		end
	end

	wire [`IDA_DW-1:0] alu_result;
	wire               alu_we;
	wire               alu_c;
	wire               alu_z;

	ida_alu u_alu (
		.op        (alu_op),
		.a         (first_register_data),
		.b         (operand_b),
		.carry_in  (carry_flag),
		.result    (alu_result),
		.write_en  (alu_we),
		.carry_out (alu_c),
		.zero_out  (alu_z)
	);

	wire alu_active = instr_valid & (alu_op != `IDA_ALU_NONE);

	// Flags, register write and interrupt enable update on executed words
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_flag       <= 1'b0;
			zero_flag        <= 1'b0;
			interrupt_enable <= 1'b0;
			reg_write        <= 1'b0;
			reg_write_index  <= `IDA_ZERO4;
			reg_write_data   <= `IDA_ZERO8;
		end else begin
			reg_write <= alu_active & alu_we;                              // [RL1] [RL8]
			if (alu_active) begin
				carry_flag      <= alu_c;                                  // [RL2] [RL6] [RL9]
				zero_flag       <= alu_z;                                  // [RL3] [RL5] [RL8]
				reg_write_index <= first_register_operand;                 // [RL4]
				reg_write_data  <= alu_result;
			end
			if (instr_valid & m_intc) begin
				interrupt_enable <= instr[0];                              // [RL19]
			end
		end
	end

	// Program counter: taken branches load target, the rest step by one
	wire take_branch = (m_call | m_jump) & (~m_cond | cond_true);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			program_counter <= `IDA_ZERO10;
		end else if (instr_valid) begin
			if (take_branch) begin
				program_counter <= instr[`IDA_A_HI:`IDA_A_LO];            // [RL16] [RL18]
			end else begin
				program_counter <= program_counter + `IDA_PC_ONE;         // [RL22]
			end
		end
	end

	// Registered decode strobes and operand fields for the downstream logic
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_add               <= 1'b0;
			dec_add_with_carry_op <= 1'b0;
			dec_and               <= 1'b0;
			dec_compare           <= 1'b0;
			dec_fetch             <= 1'b0;
			dec_input             <= 1'b0;
			dec_call              <= 1'b0;
			dec_jump              <= 1'b0;
			dec_branch_taken      <= 1'b0;
			dec_illegal           <= 1'b0;
			use_register_operand  <= 1'b0;
			immediate_constant    <= `IDA_ZERO8;
			port_number           <= `IDA_ZERO8;
			scratch_address       <= {`IDA_SPW{1'b0}};
			branch_target         <= `IDA_ZERO10;
		end else begin
			dec_add               <= instr_valid & m_add;                 // [RL12]
			dec_add_with_carry_op <= instr_valid & m_addc;                // [RL12]
			dec_and               <= instr_valid & m_and;                 // [RL13]
			dec_compare           <= instr_valid & m_cmp;                 // [RL13]
			dec_fetch             <= instr_valid & m_fetch;               // [RL14]
			dec_input             <= instr_valid & m_input;               // [RL15]
			dec_call              <= instr_valid & m_call;                // [RL16]
			dec_jump              <= instr_valid & m_jump;                // [RL18]
			dec_branch_taken      <= instr_valid & take_branch;          // [RL17]
			dec_illegal           <= instr_valid & ~m_known;              // [RL23]
			use_register_operand  <= sel;
			immediate_constant    <= kfield;
			// Port comes from the word or from the second register
			port_number           <= operand_b;                           // [RL15] [RL21]
			// Upper two address bits are dropped: 64 locations only
			scratch_address       <= operand_b[`IDA_SP_HI:0];             // [RL14] [RL20] [RL21]
			branch_target         <= instr[`IDA_A_HI:`IDA_A_LO];
		end
	end

endmodule // ida_decoder
`default_nettype wire

// ### rtl/ida_defs.vh
// Constants for the instruction decoder and its three data-path operations
// Behaviour
// RL1: Subtract-with-borrow stores first minus operand minus carry
// RL2: Borrow out sets carry, else cleared
// RL3: Zero set when 8-bit difference is zero
// RL4: Operand is register or immediate; result to first
// RL5: Bit-test ANDs, sets zero, keeps register
// RL6: Bit-test carry is parity of AND result
// RL7: Bit-test mask from register or immediate
// RL8: XOR stores result, zero flag from result
// RL9: XOR always clears carry
// RL10: 18-bit word; first register index bits 11:8
// RL11: Bit 12 picks immediate or second register
// RL12: Decode add and add-with-carry opcodes
// RL13: Decode logical AND and compare opcodes
// RL14: Decode scratchpad fetch, direct or indirect
// RL15: Decode port input, direct or indirect
// RL16: Decode call, unconditional and conditional, 10-bit target
// RL17: Condition field picks zero/carry set/clear
// RL18: Decode jump, unconditional and conditional
// RL19: Decode interrupt enable and disable
// RL20: Scratchpad address keeps six low bits
// RL21: Scratch field is address, port field port
// RL22: These operations advance program counter by one
// RL23: Flag words matching no known pattern
`ifndef IDA_DEFS_VH
`define IDA_DEFS_VH

`define IDA_IW          18
`define IDA_DW          8
`define IDA_AW          10
`define IDA_SPW         6
`define IDA_OP5_HI      17
`define IDA_OP5_LO      13
`define IDA_OP6_LO      12
`define IDA_SEL_BIT     12
`define IDA_RX_HI       11
`define IDA_RX_LO       8
`define IDA_RY_HI       7
`define IDA_RY_LO       4
`define IDA_K_HI        7
`define IDA_K_LO        0
`define IDA_COND_HI     11
`define IDA_COND_LO     10
`define IDA_A_HI        9
`define IDA_A_LO        0
`define IDA_SP_HI       5
`define IDA_LOW4_HI     3
`define IDA_HI2_HI      7
`define IDA_HI2_LO      6
`define IDA_IE_MID_HI   11
`define IDA_IE_MID_LO   1
`define IDA_OP_ADD      5'h0C
`define IDA_OP_ADDC     5'h0D
`define IDA_OP_AND      5'h05
`define IDA_OP_CMP      5'h0A
`define IDA_OP_FETCH    5'h03
`define IDA_OP_INPUT    5'h02
`define IDA_OP_SUBC     5'h0F
`define IDA_OP_TEST     5'h09
`define IDA_OP_XOR      5'h07
`define IDA_OP6_CALL    6'h30
`define IDA_OP6_CALLC   6'h31
`define IDA_OP6_JUMP    6'h34
`define IDA_OP6_JUMPC   6'h35
`define IDA_OP6_INTC    6'h3C
`define IDA_CC_Z        2'h0
`define IDA_CC_NZ       2'h1
`define IDA_CC_C        2'h2
`define IDA_CC_NC       2'h3
`define IDA_ALU_NONE    2'h0
`define IDA_ALU_SUBC    2'h1
`define IDA_ALU_TEST    2'h2
`define IDA_ALU_XOR     2'h3
`define IDA_PC_ONE      10'h001
`define IDA_ZERO4       4'h0
`define IDA_ZERO2       2'h0
`define IDA_ZERO11      11'h000
`define IDA_ZERO8       8'h00
`define IDA_ZERO10      10'h000

`endif

// ### tb/ida_props.sv
// Port-level checks for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module ida_props (
	// Clock, reset and instruction
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [17:0] instr,
	input wire logic        instr_valid,
	// Register read data
	input wire logic [7:0]  first_register_data,
	input wire logic [7:0]  second_register_data,
	// Results
	input wire logic [3:0]  first_register_operand,
	input wire logic        reg_write,
	input wire logic [3:0]  reg_write_index,
	input wire logic [7:0]  reg_write_data,
	input wire logic        carry_flag,
	input wire logic        zero_flag,
	input wire logic        interrupt_enable,
	input wire logic [9:0]  program_counter,
	input wire logic        dec_jump,
	input wire logic        dec_branch_taken,
	input wire logic        dec_illegal
);
	// Operand as the word selects it; register forms need a clean low nibble
	wire logic [7:0] opnd = instr[12] ? second_register_data : instr[7:0];
	wire logic       ok   = instr_valid && (!instr[12] || instr[3:0] == 4'h0);
	wire logic [8:0] diff = {1'b0, first_register_data} - {1'b0, opnd} - {8'h00, carry_flag};
	wire logic [7:0] msk  = first_register_data & opnd;
	wire logic       subc = ok && instr[17:13] == 5'h0F;
	wire logic       tst  = ok && instr[17:13] == 5'h09;
	wire logic       xr   = ok && instr[17:13] == 5'h07;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_subc_result:
	assert property (subc |=> reg_write && reg_write_data == $past(diff[7:0])
		&& reg_write_index == $past(instr[11:8])) else $error("subtract result wrong");
	a_subc_flags:
	assert property (subc |=> carry_flag == $past(diff[8])
		&& zero_flag == ($past(diff[7:0]) == 8'h00)) else $error("subtract flags wrong");
	a_test_flags:
	assert property (tst |=> !reg_write && zero_flag == ($past(msk) == 8'h00)
		&& carry_flag == ^$past(msk)) else $error("test flags wrong");
	a_xor_result:
	assert property (xr |=> reg_write && !carry_flag
		&& reg_write_data == $past(first_register_data ^ opnd)) else $error("xor wrong");
	a_pc_step:
	assert property ((subc || tst || xr) |=> program_counter == $past(program_counter) + 10'h001)
		else $error("program counter did not step");
	a_jump_taken:
	assert property (instr_valid && instr[17:10] == 8'hD0 |=> dec_jump && dec_branch_taken
		&& program_counter == $past(instr[9:0])) else $error("jump not taken");
	a_int_ctrl:
	assert property (instr_valid && instr[17:1] == 17'h1E000 |=>
		interrupt_enable == $past(instr[0])) else $error("interrupt enable wrong");
	a_idle_hold:
	assert property (!instr_valid |=> !reg_write && !dec_illegal && $stable(program_counter))
		else $error("idle cycle changed state");
	a_index_field:
	assert property (first_register_operand == instr[11:8]) else $error("index wrong");
	// Main scenarios seen
	c_borrow: cover property (subc ##1 carry_flag && zero_flag);
	c_test: cover property (tst ##1 carry_flag);
	c_xor: cover property (xr ##1 zero_flag);
endmodule // ida_props
`default_nettype wire

// ### tb/ida_regfile_model.sv
// Register file standing beside the decoder
`timescale 1ns/1ns
`default_nettype none
module ida_regfile_model (
	// Clock
	input wire logic       sys_clk,
	// Read ports, combinational as the decoder expects
	input wire logic [3:0] rd_a_index,
	input wire logic [3:0] rd_b_index,
	output logic     [7:0] rd_a_data,
	output logic     [7:0] rd_b_data,
	// Write port
	input wire logic       wr_en,
	input wire logic [3:0] wr_index,
	input wire logic [7:0] wr_data
);
	logic [7:0] mem [0:15];
	// Same-cycle reads. The write pulse lands one edge late, so a pending write
	// is passed through; otherwise a back-to-back word would read a stale register.
	assign rd_a_data = (wr_en && wr_index == rd_a_index) ? wr_data : mem[rd_a_index];
	assign rd_b_data = (wr_en && wr_index == rd_b_index) ? wr_data : mem[rd_b_index];
	// Write lands at the edge after the pulse
	always @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_index] <= wr_data;
		end
	end
endmodule // ida_regfile_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
`include "ida_defs.vh"
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [17:0] instr = 18'h00000;
	logic        instr_valid = 1'b0;
	wire  [7:0]  rd_a, rd_b, wr_data, imm, port;
	wire  [3:0]  ix_a, ix_b, wr_ix;
	wire  [5:0]  scr;
	wire  [9:0]  pc, tgt;
	wire         wr, cf, zf, ie, taken, use_reg;
	wire  [8:0]  strb;
	logic [7:0]  shadow [0:15];
	logic [9:0]  epc = 10'h000;
	logic        ec = 1'b0;
	logic        ez = 1'b0;
	logic [31:0] r;
	int          err_total = 0;
	int          checks = 0;
	logic [4:0]  ops [0:2] = '{`IDA_OP_SUBC, `IDA_OP_TEST, `IDA_OP_XOR};
	always #2 sys_clk = ~sys_clk;
	ida_decoder uut (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
		.first_register_data(rd_a), .second_register_data(rd_b),
		.first_register_operand(ix_a), .second_register_operand(ix_b), .reg_write(wr),
		.reg_write_index(wr_ix), .reg_write_data(wr_data), .carry_flag(cf), .zero_flag(zf),
		.interrupt_enable(ie), .program_counter(pc), .dec_add(strb[8]),
		.dec_add_with_carry_op(strb[7]), .dec_and(strb[6]), .dec_compare(strb[5]),
		.dec_fetch(strb[4]), .dec_input(strb[3]), .dec_call(strb[2]), .dec_jump(strb[1]),
		.dec_illegal(strb[0]), .dec_branch_taken(taken), .use_register_operand(use_reg),
		.immediate_constant(imm), .port_number(port), .scratch_address(scr), .branch_target(tgt));
	ida_regfile_model rf (.sys_clk(sys_clk), .rd_a_index(ix_a), .rd_b_index(ix_b),
		.rd_a_data(rd_a), .rd_b_data(rd_b), .wr_en(wr), .wr_index(wr_ix), .wr_data(wr_data));
	// Expected {write, data, carry, zero} of one word
	function automatic logic [10:0] alu_exp(input logic [4:0] op, input logic [7:0] a, b,
		input logic c, z);
		logic [8:0] d;
		logic [7:0] m;
		d = {1'b0, a} - {1'b0, b} - {8'h00, c};
		m = a & b;
		case (op)
			`IDA_OP_SUBC: return {1'b1, d[7:0], d[8], d[7:0] == 8'h00};
			`IDA_OP_TEST: return {1'b0, a, ^m, m == 8'h00};
			`IDA_OP_XOR: return {1'b1, a ^ b, 1'b0, (a ^ b) == 8'h00};
			default: return {1'b0, a, c, z};
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One executed word; flags and counter follow from the bench's own state
	task automatic exec(input logic [17:0] w, input logic [8:0] es);
		logic [10:0] e;
		logic        tk;
		e = alu_exp(w[17:13], shadow[w[11:8]], w[12] ? shadow[w[7:4]] : w[7:0], ec, ez);
		tk = w[17:15] == 3'b110 && !w[13] && (w[12] ? ((w[11] ? ec : ez) ^ w[10]) : w[11:10] == 2'b00);
		instr = w;
		instr_valid = 1'b1;
		@(negedge sys_clk);
		if (e[10]) shadow[w[11:8]] = e[9:2];
		{ec, ez} = e[1:0];
		epc = tk ? w[9:0] : epc + 10'h001;
		chk({wr, cf, zf}, {e[10], e[1:0]});
		if (e[10]) chk({wr_ix, wr_data}, {w[11:8], e[9:2]});
		chk({pc, taken}, {epc, tk});
		chk(strb, es);
		chk({ix_a, ix_b, use_reg, imm, tgt}, {w[11:4], w[12], w[7:0], w[9:0]});
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#200000;
		err_total++;
		test_done();
	end
	initial begin
		void'($urandom(32'h6d943de0));
		for (int i = 0; i < 16; i++) begin
			shadow[i] = 8'($urandom);
			rf.mem[i] = shadow[i];
		end
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		chk({pc, cf, zf, ie, wr, strb}, 32'h0);
		// Clear, borrow into a result of minus 256, parity and zero test
		exec({5'h07, 1'b1, 4'h1, 4'h1, 4'h0}, 9'h000);
		exec({5'h07, 1'b1, 4'h2, 4'h2, 4'h0}, 9'h000);
		exec({5'h0F, 1'b0, 4'h1, 8'h01}, 9'h000);
		exec({5'h0F, 1'b0, 4'h2, 8'hFF}, 9'h000);
		exec({5'h09, 1'b0, 4'h1, 8'h07}, 9'h000);
		exec({5'h09, 1'b1, 4'h1, 4'h2, 4'h0}, 9'h000);
		// Decode classes, fields and branches
		exec({5'h0C, 1'b0, 4'h3, 8'h5A}, 9'h100);
		chk(imm, 8'h5A);
		exec({5'h0D, 1'b1, 4'h3, 4'h4, 4'h0}, 9'h080);
		exec({5'h05, 1'b0, 4'h3, 8'h11}, 9'h040);
		exec({5'h0A, 1'b1, 4'h3, 4'h4, 4'h0}, 9'h020);
		exec({5'h03, 1'b1, 4'h3, 4'h1, 4'h0}, 9'h010);
		chk(scr, 6'h3F);
		exec({5'h03, 1'b0, 4'h3, 8'h80}, 9'h001);
		exec({5'h02, 1'b0, 4'h3, 8'hA5}, 9'h008);
		chk(port, 8'hA5);
		exec({5'h02, 1'b1, 4'h3, 4'h1, 4'h0}, 9'h008);
		chk(port, shadow[1]);
		exec({6'h30, 2'h0, 10'h155}, 9'h004);
		exec({6'h35, 2'h0, 10'h2AA}, 9'h002);
		exec({6'h31, 2'h2, 10'h0F0}, 9'h004);
		exec({6'h35, 2'h3, 10'h333}, 9'h002);
		exec({6'h34, 2'h0, 10'h1C7}, 9'h002);
		exec(18'h3FFFF, 9'h001);
		exec({6'h3C, 12'h001}, 9'h000);
		chk(ie, 1'b1);
		exec({6'h3C, 12'h000}, 9'h000);
		chk(ie, 1'b0);
		// Random back-to-back traffic with idle gaps
		repeat (400) begin
			r = $urandom;
			if (r[31:29] == 3'h0) begin
				instr = r[17:0];
				instr_valid = 1'b0;
				@(negedge sys_clk);
				chk({pc, wr, cf, zf}, {epc, 1'b0, ec, ez});
			end else if (r[28]) begin
				exec({ops[r[27:26] % 3], 1'b1, r[11:4], 4'h0}, 9'h000);
			end else begin
				exec({ops[r[27:26] % 3], 1'b0, r[11:8], r[19:12]}, 9'h000);
			end
		end
		instr_valid = 1'b0;
		test_done();
	end
endmodule // testbench
bind ida_decoder ida_props chk (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr),
	.instr_valid(instr_valid), .first_register_data(first_register_data),
	.second_register_data(second_register_data), .first_register_operand(first_register_operand),
	.reg_write(reg_write), .reg_write_index(reg_write_index), .reg_write_data(reg_write_data),
	.carry_flag(carry_flag), .zero_flag(zero_flag), .interrupt_enable(interrupt_enable),
	.program_counter(program_counter), .dec_jump(dec_jump),
	.dec_branch_taken(dec_branch_taken), .dec_illegal(dec_illegal));
`default_nettype wire
